// file: verilog/gpa_pkg.sv
package gpa_pkg;
  localparam int unsigned PORT_W = 8;

  localparam logic [31:0] BASE_ADDR      = 32'h4000_0000;
  localparam logic [11:0] OFS_DATA       = 12'h000;
  localparam logic [11:0] OFS_OUT_EN     = 12'h004;
  localparam logic [11:0] OFS_FUNC_ONE   = 12'h008;
  localparam logic [11:0] OFS_PULLUP     = 12'h02c;
  localparam logic [11:0] OFS_PULLDOWN   = 12'h030;
  localparam logic [11:0] OFS_INPUT_EN   = 12'h038;
  localparam logic [11:0] OFS_OPEN_DRAIN = 12'h040;
  localparam logic [11:0] OFS_STANDBY    = 12'h044;
  localparam logic [11:0] OFS_INT_SEL    = 12'h048;
  localparam logic [11:0] ADDR_LOW_MASK  = 12'hfff;

  localparam logic [7:0] RST_DATA       = 8'h00;
  localparam logic [7:0] RST_OUT_EN     = 8'h01;
  localparam logic [7:0] RST_FUNC_ONE   = 8'h03;
  localparam logic [7:0] RST_PULLUP     = 8'h01;
  localparam logic [7:0] RST_PULLDOWN   = 8'h02;
  localparam logic [7:0] RST_INPUT_EN   = 8'h03;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_INT_SEL    = 8'h00;
  localparam logic       RST_DRIVE_KEEP = 1'b0;

  // writable masks: pull-up absent on bit 1, pull-down only on bit 1, no function on bit 7
  localparam logic [7:0] MASK_PULLUP    = 8'hfd;
  localparam logic [7:0] MASK_PULLDOWN  = 8'h02;
  localparam logic [7:0] MASK_FUNC_ONE  = 8'h7f;
  localparam logic [7:0] MASK_ALL       = 8'hff;

  localparam int unsigned BIT_DEBUG_IO  = 0;
  localparam int unsigned BIT_DEBUG_CLK = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic [PORT_W-1:0] out_val;
    logic [PORT_W-1:0] out_en;
    logic [PORT_W-1:0] in_en;
    logic [PORT_W-1:0] pull_up;
    logic [PORT_W-1:0] pull_down;
  } gpa_pad_s;

  typedef struct packed {
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] out_en;
    logic [PORT_W-1:0] func;
    logic [PORT_W-1:0] pull_up;
    logic [PORT_W-1:0] pull_down;
    logic [PORT_W-1:0] in_en;
    logic [PORT_W-1:0] open_drain;
    logic [PORT_W-1:0] int_sel;
    logic              drive_keep;
  } gpa_cfg_s;
endpackage

// file: verilog/gpa_pad_ctrl.sv
`timescale 1ns/1ns
module gpa_pad_ctrl #(
  parameter int unsigned W = 8
) (
  input  wire logic             stop_mode,
  input  wire gpa_pkg::gpa_cfg_s cfg,
  input  wire logic [W-1:0]     periph_out,
  input  wire logic [W-1:0]     periph_oe,
  input  wire logic [W-1:0]     debug_valid,
  output      gpa_pkg::gpa_pad_s pad
);
  logic [W-1:0] func_out;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic base_oe;
      logic dbg_pin;
      logic int_pin;
      logic run_oe;
      always_comb
      begin
        dbg_pin     = (i == gpa_pkg::BIT_DEBUG_IO) && cfg.func[i];
        // debug data pin never counts as an interrupt pin: its stop input follows drive-keep
        int_pin     = cfg.int_sel[i] && cfg.func[i] && cfg.in_en[i] && !dbg_pin;
        // port mode drives data, function mode drives peripheral
        func_out[i] = cfg.func[i] ? periph_out[i] : cfg.data[i];
        base_oe     = cfg.out_en[i] && (!cfg.func[i] || periph_oe[i]);
        run_oe      = base_oe && !cfg.open_drain[i];
        pad.out_val[i]   = func_out[i];
        pad.pull_up[i]   = cfg.pull_up[i];
        pad.pull_down[i] = cfg.pull_down[i];
        if (!stop_mode)
        begin
          pad.out_en[i] = run_oe;
          pad.in_en[i]  = cfg.in_en[i];
        end
        else if (dbg_pin && cfg.out_en[i])
        begin
          // debug data pin output ignores drive-keep and follows its own valid
          pad.out_en[i] = debug_valid[i];
          pad.in_en[i]  = cfg.drive_keep && cfg.in_en[i];
        end
        else if (int_pin)
        begin
          pad.in_en[i]  = 1'b1;
          pad.out_en[i] = cfg.drive_keep && run_oe;
        end
        else
        begin
          pad.out_en[i] = cfg.drive_keep && run_oe;
          pad.in_en[i]  = cfg.drive_keep && cfg.in_en[i];
        end
      end
    end
  endgenerate
endmodule // gpa_pad_ctrl

// file: verilog/gpa_port.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
// Overview of operation
// - data register at 0x0000: reads pin levels, writes output values
// - output control at 0x0004 enables each pin's output driver
// - function bit 1 routes pin to its peripheral; register at 0x0008
// - open-drain bit 1 disables output buffer, pseudo open-drain
// - pull-up control at 0x002C per pin except bit 1
// - pull-down control at 0x0030, bit 1 only
// - input control at 0x0038 gates input buffers, on by default for bits 0 and 1 only
// - stop with drive-keep 1: inputs and outputs follow enables
// - stop with drive-keep 0: ordinary pins lose input and output
// - interrupt pins keep input in stop; output only with drive-keep
// - stop: debug pin drives only while its debug data is valid
// - eight bits, each direction set independently
// - reset: bit 0 debug data pin, input, output, pull-up on
// - reset: bit 1 debug clock pin, input and pull-down on
// - reset: bits 2..7 plain pins, input, output, pull-up off
// - bit 0 debug output follows its debug valid in stop despite drive-keep
// - registers decoded from base 0x4000_0000
module gpa_port #(
  parameter int unsigned W = gpa_pkg::PORT_W
) (
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic         HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  output      logic [31:0]  HRDATA,
  output      logic         HREADYOUT,
  output      logic         HRESP,
  input  wire logic         STOP_MODE,
  input  wire logic [W-1:0] PIN_IN,
  output      logic [W-1:0] PIN_OUT,
  output      logic [W-1:0] PIN_OE,
  output      logic [W-1:0] PIN_IE,
  output      logic [W-1:0] PIN_PULLUP,
  output      logic [W-1:0] PIN_PULLDOWN,
  input  wire logic [W-1:0] PERIPH_OUT,
  input  wire logic [W-1:0] PERIPH_OE,
  input  wire logic [W-1:0] DEBUG_VALID,
  output      logic [W-1:0] PERIPH_IN
);
  gpa_pkg::gpa_cfg_s cfg_ff;
  gpa_pkg::gpa_cfg_s nxt_cfg;
  gpa_pkg::gpa_pad_s pad_comb;
  gpa_pkg::gpa_pad_s pad_ff;
  logic [W-1:0]      pin_meta_ff;
  logic [W-1:0]      pin_sync_ff;
  logic [W-1:0]      periph_in_ff;
  logic [W-1:0]      nxt_periph_in;
  logic              stop_meta_ff;
  logic              stop_sync_ff;
  logic              wr_pend_ff;
  logic              nxt_wr_pend;
  logic [11:0]       wr_ofs_ff;
  logic [11:0]       nxt_wr_ofs;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              addr_phase;
  logic              base_hit;
  logic [11:0]       ofs;
  logic [W-1:0]      wbyte;

  // ahb-lite slave: zero wait states, write lands one cycle after address phase
  always_comb
  begin
    addr_phase  = HSEL && HREADY && (HTRANS == gpa_pkg::HTRANS_NONSEQ);
    base_hit    = (HADDR & ~{20'h0_0000, gpa_pkg::ADDR_LOW_MASK}) == gpa_pkg::BASE_ADDR;
    ofs         = HADDR[11:0];
    nxt_wr_pend = addr_phase && HWRITE && base_hit;
    nxt_wr_ofs  = ofs;
    nxt_rdata   = 32'h0000_0000;
    if (addr_phase && !HWRITE && base_hit)
    begin
      unique case (ofs)
        gpa_pkg::OFS_DATA:       nxt_rdata[W-1:0] = pin_sync_ff;
        gpa_pkg::OFS_OUT_EN:     nxt_rdata[W-1:0] = cfg_ff.out_en;
        gpa_pkg::OFS_FUNC_ONE:   nxt_rdata[W-1:0] = cfg_ff.func;
        gpa_pkg::OFS_PULLUP:     nxt_rdata[W-1:0] = cfg_ff.pull_up;
        gpa_pkg::OFS_PULLDOWN:   nxt_rdata[W-1:0] = cfg_ff.pull_down;
        gpa_pkg::OFS_INPUT_EN:   nxt_rdata[W-1:0] = cfg_ff.in_en;
        gpa_pkg::OFS_OPEN_DRAIN: nxt_rdata[W-1:0] = cfg_ff.open_drain;
        gpa_pkg::OFS_STANDBY:    nxt_rdata[0]     = cfg_ff.drive_keep;
        gpa_pkg::OFS_INT_SEL:    nxt_rdata[W-1:0] = cfg_ff.int_sel;
        default:                 nxt_rdata        = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    wbyte   = HWDATA[W-1:0];
    nxt_cfg = cfg_ff;
    if (wr_pend_ff)
    begin
      unique case (wr_ofs_ff)
        gpa_pkg::OFS_DATA:       nxt_cfg.data       = wbyte;
        gpa_pkg::OFS_OUT_EN:     nxt_cfg.out_en     = wbyte;
        gpa_pkg::OFS_FUNC_ONE:   nxt_cfg.func       = wbyte & gpa_pkg::MASK_FUNC_ONE;
        gpa_pkg::OFS_PULLUP:     nxt_cfg.pull_up    = wbyte & gpa_pkg::MASK_PULLUP;
        gpa_pkg::OFS_PULLDOWN:   nxt_cfg.pull_down  = wbyte & gpa_pkg::MASK_PULLDOWN;
        gpa_pkg::OFS_INPUT_EN:   nxt_cfg.in_en      = wbyte;
        gpa_pkg::OFS_OPEN_DRAIN: nxt_cfg.open_drain = wbyte;
        gpa_pkg::OFS_STANDBY:    nxt_cfg.drive_keep = HWDATA[0];
        gpa_pkg::OFS_INT_SEL:    nxt_cfg.int_sel    = wbyte;
        default:                 nxt_cfg            = cfg_ff;
      endcase
    end
  end

  // input path only passes synchronized level when its buffer is enabled
  always_comb
  begin
    nxt_periph_in = pin_sync_ff & pad_ff.in_en;
  end

  gpa_pad_ctrl #(
    .W (W)
  ) u_pad (
    .stop_mode   (stop_sync_ff),
    .cfg         (cfg_ff),
    .periph_out  (PERIPH_OUT),
    .periph_oe   (PERIPH_OE),
    .debug_valid (DEBUG_VALID),
    .pad         (pad_comb)
  );

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cfg_ff.data       <= gpa_pkg::RST_DATA;
      cfg_ff.out_en     <= gpa_pkg::RST_OUT_EN;
      cfg_ff.func       <= gpa_pkg::RST_FUNC_ONE;
      cfg_ff.pull_up    <= gpa_pkg::RST_PULLUP;
      cfg_ff.pull_down  <= gpa_pkg::RST_PULLDOWN;
      cfg_ff.in_en      <= gpa_pkg::RST_INPUT_EN;
      cfg_ff.open_drain <= gpa_pkg::RST_OPEN_DRAIN;
      cfg_ff.int_sel    <= gpa_pkg::RST_INT_SEL;
      cfg_ff.drive_keep <= gpa_pkg::RST_DRIVE_KEEP;
      pad_ff            <= '0;
      periph_in_ff      <= '0;
      pin_meta_ff       <= '0;
      pin_sync_ff       <= '0;
      stop_meta_ff      <= 1'b0;
      stop_sync_ff      <= 1'b0;
      wr_pend_ff        <= 1'b0;
      wr_ofs_ff         <= 12'h000;
      rdata_ff          <= 32'h0000_0000;
    end
    else
    begin
      cfg_ff       <= nxt_cfg;
      pad_ff       <= pad_comb;
      periph_in_ff <= nxt_periph_in;
      pin_meta_ff  <= PIN_IN;
      pin_sync_ff  <= pin_meta_ff;
      stop_meta_ff <= STOP_MODE;
      stop_sync_ff <= stop_meta_ff;
      wr_pend_ff   <= nxt_wr_pend;
      wr_ofs_ff    <= nxt_wr_ofs;
      rdata_ff     <= nxt_rdata;
    end
  end

  always_comb
  begin
    HRDATA       = rdata_ff;
    HREADYOUT    = 1'b1;
    HRESP        = 1'b0;
    PIN_OUT      = pad_ff.out_val;
    PIN_OE       = pad_ff.out_en;
    PIN_IE       = pad_ff.in_en;
    PIN_PULLUP   = pad_ff.pull_up;
    PIN_PULLDOWN = pad_ff.pull_down;
    PERIPH_IN    = periph_in_ff;
  end

  AST_RESET_DEBUG_PINS: assert property (@(posedge CLK)
    ($past(SYS_RST) && !SYS_RST)
      |-> cfg_ff.func == gpa_pkg::RST_FUNC_ONE && cfg_ff.in_en == gpa_pkg::RST_INPUT_EN)
    else $error("debug pins not selected after reset");

  AST_RESET_PULLS: assert property (@(posedge CLK)
    ($past(SYS_RST) && !SYS_RST) |-> cfg_ff.pull_up == gpa_pkg::RST_PULLUP
                       && cfg_ff.pull_down == gpa_pkg::RST_PULLDOWN)
    else $error("pull reset values wrong");

  AST_RESET_PLAIN: assert property (@(posedge CLK)
    ($past(SYS_RST) && !SYS_RST) |-> cfg_ff.out_en == gpa_pkg::RST_OUT_EN)
    else $error("plain pins enabled after reset");

  AST_OPEN_DRAIN: assert property (@(posedge CLK) disable iff (SYS_RST)
    ($past(cfg_ff.open_drain[2]) && !$past(stop_sync_ff)) |-> !PIN_OE[2])
    else $error("open-drain pin still drives");

  AST_STOP_NO_KEEP: assert property (@(posedge CLK) disable iff (SYS_RST)
    ($past(stop_sync_ff) && !$past(cfg_ff.drive_keep) && !$past(cfg_ff.func[2]))
      |-> !PIN_OE[2] && !PIN_IE[2])
    else $error("ordinary pin active in stop without keep");

  AST_STOP_KEEP: assert property (@(posedge CLK) disable iff (SYS_RST)
    ($past(stop_sync_ff) && $past(cfg_ff.drive_keep) && !$past(cfg_ff.func[3]))
      |-> PIN_IE[3] == $past(cfg_ff.in_en[3]))
    else $error("kept pin input does not follow enable");

  AST_DEBUG_STOP: assert property (@(posedge CLK) disable iff (SYS_RST)
    ($past(stop_sync_ff) && $past(cfg_ff.func[0]) && $past(cfg_ff.out_en[0]))
      |-> PIN_OE[0] == $past(DEBUG_VALID[0]))
    else $error("debug pin drive not tied to valid");

  sequence s_write_data;
    HSEL && HREADY && HTRANS == gpa_pkg::HTRANS_NONSEQ && HWRITE
      && HADDR == gpa_pkg::BASE_ADDR;
  endsequence

  AST_DATA_WRITE: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_write_data ##1 1'b1 |=> cfg_ff.data == $past(HWDATA[W-1:0]))
    else $error("data write lost");

  AST_PORT_DRIVE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!$past(cfg_ff.func[5]) && $past(cfg_ff.out_en[5]) && !$past(cfg_ff.open_drain[5])
      && !$past(stop_sync_ff)) |-> PIN_OE[5] && PIN_OUT[5] == $past(cfg_ff.data[5]))
    else $error("port pin not driving data");
endmodule // gpa_port

// file: bench/gpa_pin_model.sv
`timescale 1ns/1ns
module gpa_pin_model (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pu,
  input  wire logic [7:0] pad_pd,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output      logic [7:0] level
);
  // an undriven, unpulled pin reads the inverse of the port value, never a kept level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_oe[i])
        level[i] = pad_out[i];
      else if (ext_drv[i])
        level[i] = ext_val[i];
      else if (pad_pu[i] | pad_pd[i])
        level[i] = pad_pu[i];
      else
        level[i] = ~pad_out[i];
    end
  end
endmodule // gpa_pin_model

// file: bench/gpa_port_tb.sv
`timescale 1ns/1ns
module gpa_port_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic        stop = 1'b0;
  logic [7:0]  p_out = 8'h00, p_oe = 8'h00, dbg_v = 8'h00, ext_val = 8'h00, ext_drv = 8'h00;
  logic [31:0] hrdata;
  logic        hready, hresp;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_ie, pin_pu, pin_pd, per_in;
  logic [7:0]  m_dat, m_oe, m_fn, m_pu, m_pd, m_ie, m_is;
  logic        m_dk;
  int          n_mismatch = 0;
  int          n_checks = 0;

  always #10 clk = ~clk;

  gpa_port i_dut (.CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .STOP_MODE(stop), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_IE(pin_ie), .PIN_PULLUP(pin_pu), .PIN_PULLDOWN(pin_pd),
    .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .DEBUG_VALID(dbg_v), .PERIPH_IN(per_in));

  gpa_pin_model i_pins (.pad_out(pin_out), .pad_oe(pin_oe), .pad_pu(pin_pu), .pad_pd(pin_pd),
    .ext_val(ext_val), .ext_drv(ext_drv), .level(pin_in));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= gpa_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= gpa_pkg::HSIZE_WORD;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
    // idle cycle so a following read sees this write
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] o, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, gpa_pkg::BASE_ADDR + 32'(o), v, d);
    case (o)
      gpa_pkg::OFS_DATA:     m_dat = v[7:0];
      gpa_pkg::OFS_OUT_EN:   m_oe = v[7:0];
      gpa_pkg::OFS_FUNC_ONE: m_fn = v[7:0] & gpa_pkg::MASK_FUNC_ONE;
      gpa_pkg::OFS_PULLUP:   m_pu = v[7:0] & gpa_pkg::MASK_PULLUP;
      gpa_pkg::OFS_PULLDOWN: m_pd = v[7:0] & gpa_pkg::MASK_PULLDOWN;
      gpa_pkg::OFS_INPUT_EN: m_ie = v[7:0];
      gpa_pkg::OFS_INT_SEL:  m_is = v[7:0];
      gpa_pkg::OFS_STANDBY:  m_dk = v[0];
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [11:0] o, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, gpa_pkg::BASE_ADDR + 32'(o), 32'h0, d);
    chk(d, e);
  endtask

  function automatic logic [7:0] e_oe();
    logic [7:0] n;
    n = (m_fn & m_oe & p_oe) | (~m_fn & m_oe);
    if (stop)
    begin
      n = m_dk ? n : 8'h00;
      if (m_fn[0] & m_oe[0])
        n[0] = dbg_v[0];
    end
    return n;
  endfunction

  function automatic logic [7:0] e_ie();
    // bit 0 is the debug pin, never an interrupt pin
    return !stop ? m_ie : (m_dk ? m_ie : (m_is & m_fn & m_ie & 8'hfe));
  endfunction

  task automatic pads();
    repeat (6) @(posedge clk);
    chk(32'(pin_oe), 32'(e_oe()));
    chk(32'(pin_ie), 32'(e_ie()));
    if (!stop)
    begin
      chk(32'(pin_out & pin_oe), 32'(((m_fn & p_out) | (~m_fn & m_dat)) & e_oe()));
      chk(32'(pin_pu), 32'(m_pu));
      chk(32'(pin_pd), 32'(m_pd));
    end
  endtask

  initial
  begin
    logic [31:0] r;
    r = $urandom(32'hf614ac9c);
    {m_dat, m_oe, m_fn, m_pu, m_pd, m_ie, m_is, m_dk} = {8'h00, 8'h01, 8'h03, 8'h01, 8'h02,
                                                         8'h03, 8'h00, 1'b0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pads();
    rd_chk(gpa_pkg::OFS_OUT_EN, 32'h01);
    rd_chk(gpa_pkg::OFS_FUNC_ONE, 32'h03);
    rd_chk(gpa_pkg::OFS_PULLUP, 32'h01);
    rd_chk(gpa_pkg::OFS_PULLDOWN, 32'h02);
    rd_chk(gpa_pkg::OFS_INPUT_EN, 32'h03);
    rd_chk(gpa_pkg::OFS_OPEN_DRAIN, 32'h00);
    rd_chk(gpa_pkg::OFS_STANDBY, 32'h00);
    rd_chk(gpa_pkg::OFS_INT_SEL, 32'h00);
    rd_chk(12'h00c, 32'h0);
    bus(1'b1, gpa_pkg::BASE_ADDR + 32'h1004, 32'hff, r);
    rd_chk(gpa_pkg::OFS_OUT_EN, 32'h01);
    wr(gpa_pkg::OFS_FUNC_ONE, 32'h0);
    wr(gpa_pkg::OFS_INPUT_EN, 32'hff);
    wr(gpa_pkg::OFS_OUT_EN, 32'hff);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      wr(gpa_pkg::OFS_DATA, r);
      repeat (4) @(posedge clk);
      rd_chk(gpa_pkg::OFS_DATA, 32'(r[7:0]));
      chk(32'(per_in), 32'(r[7:0]));
    end
    wr(gpa_pkg::OFS_OUT_EN, 32'h0);
    ext_drv <= 8'hff;
    ext_val <= 8'($urandom);
    repeat (4) @(posedge clk);
    rd_chk(gpa_pkg::OFS_DATA, 32'(ext_val));
    for (int i = 0; i < 24; i++)
    begin
      wr(gpa_pkg::OFS_OPEN_DRAIN, $urandom);
      rd_chk(gpa_pkg::OFS_OPEN_DRAIN, 32'(8'(hwdata)));
      wr(gpa_pkg::OFS_OPEN_DRAIN, 32'h0);
      wr(gpa_pkg::OFS_DATA, $urandom);
      wr(gpa_pkg::OFS_OUT_EN, $urandom);
      wr(gpa_pkg::OFS_FUNC_ONE, $urandom);
      wr(gpa_pkg::OFS_PULLUP, $urandom);
      wr(gpa_pkg::OFS_PULLDOWN, $urandom);
      wr(gpa_pkg::OFS_INPUT_EN, $urandom);
      wr(gpa_pkg::OFS_INT_SEL, $urandom);
      wr(gpa_pkg::OFS_STANDBY, $urandom);
      p_out <= 8'($urandom);
      p_oe <= 8'($urandom);
      dbg_v <= 8'($urandom);
      stop <= ($urandom % 3) != 0;
      pads();
      rd_chk(gpa_pkg::OFS_FUNC_ONE, 32'(m_fn));
      rd_chk(gpa_pkg::OFS_PULLUP, 32'(m_pu));
      rd_chk(gpa_pkg::OFS_PULLDOWN, 32'(m_pd));
      rd_chk(gpa_pkg::OFS_STANDBY, 32'(m_dk));
      stop <= 1'b0;
    end
    tally_and_finish();
  end

  initial
  begin
    #(20 * 20000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // gpa_port_tb
